//--- verilog/analog_scan_control_segment.sv
`timescale 1ns/10ps
module analog_scan_control_segment (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Raw analog observations
    input  wire logic        comparator_raw,
    input  wire logic        converter_compare_raw,
    // Analog comparator controls and observed result
    output logic             comparator_off,
    output logic             comparator_mux_select,
    output logic             comparator_bandgap_enable,
    output logic             comparator_result,
    // Converter controls and observed compare result
    output logic             gain_clock,
    output logic             gain_path_enable,
    output logic             neg_input_bandgap_select,
    output logic             converter_power_on,
    output logic             gain_stage_power_on,
    output logic       [9:0] dac_code,
    output logic             gain_bypass_select,
    output logic             gain_x10_enable,
    output logic             gain_x20_enable,
    output logic             neg_input_ground_select,
    output logic             sample_hold,
    output logic             converter_compare
);

    localparam int CW = scan_seg_pkg::CTRL_W;
    localparam int NW = scan_seg_pkg::CHAIN_W;
    localparam int LW = scan_seg_pkg::CMD_LEN_W;

    scan_seg_pkg::shift_state_t state_q;
    scan_seg_pkg::shift_state_t state_d;
    logic [CW-1:0] latch_q;
    logic [CW-1:0] latch_d;
    logic [NW-1:0] chain_q;
    logic [NW-1:0] chain_d;
    logic [31:0]   shift_in_q;
    logic [31:0]   shift_in_d;
    logic [31:0]   shift_out_q;
    logic [31:0]   shift_out_d;
    logic [LW-1:0] count_q;
    logic [LW-1:0] count_d;
    logic [LW-1:0] len_q;
    logic [LW-1:0] len_d;
    logic          pend_upd_q;
    logic          pend_upd_d;
    logic [31:0]   prdata_q;
    logic [31:0]   prdata_d;
    logic          obs_comparator;
    logic          obs_converter;
    logic          wr_access;
    logic          rd_setup;
    logic          busy;

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == scan_seg_pkg::CMD_OFFSET)
                   || (a == scan_seg_pkg::SHIFT_IN_OFFSET)
                   || (a == scan_seg_pkg::SHIFT_OUT_OFFSET)
                   || (a == scan_seg_pkg::STATUS_OFFSET)
                   || (a == scan_seg_pkg::LATCH_OFFSET);
    endfunction

    // Observed values, forced low while the analog part is off
    assign obs_comparator = comparator_raw & ~latch_q[
        scan_seg_pkg::CELL_COMPARATOR_OFF];
    assign obs_converter  = converter_compare_raw & latch_q[
        scan_seg_pkg::CELL_CONVERTER_POWER];

    assign busy      = (state_q == scan_seg_pkg::ST_SHIFT);
    assign wr_access = psel & penable & pwrite;
    assign rd_setup  = psel & ~penable & ~pwrite;

    // APB answer: zero wait states, data prepared in setup phase
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_mapped(paddr);
    assign prdata  = prdata_q;

    // Read data path
    always_comb begin
        prdata_d = prdata_q;
        if (rd_setup) begin
            prdata_d = 32'h00000000;
            unique case (paddr)
                scan_seg_pkg::CMD_OFFSET: begin
                    prdata_d[scan_seg_pkg::CMD_LEN_LSB +: LW] = len_q;
                end
                scan_seg_pkg::SHIFT_IN_OFFSET: begin
                    prdata_d = shift_in_q;
                end
                scan_seg_pkg::SHIFT_OUT_OFFSET: begin
                    prdata_d = shift_out_q;
                end
                scan_seg_pkg::STATUS_OFFSET: begin
                    prdata_d[scan_seg_pkg::STAT_BUSY_BIT] = busy;
                    prdata_d[scan_seg_pkg::STAT_ACO_BIT]  = obs_comparator;
                    prdata_d[scan_seg_pkg::STAT_COMP_BIT] = obs_converter;
                end
                scan_seg_pkg::LATCH_OFFSET: begin
                    prdata_d[CW-1:0] = latch_q;
                end
                default: begin
                    prdata_d = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    // Scan sequencer: capture, shift, update
    always_comb begin
        state_d     = state_q;
        latch_d     = latch_q;
        chain_d     = chain_q;
        shift_in_d  = shift_in_q;
        shift_out_d = shift_out_q;
        count_d     = count_q;
        len_d       = len_q;
        pend_upd_d  = pend_upd_q;
        unique case (state_q)
            scan_seg_pkg::ST_IDLE: begin
                if (wr_access && paddr == scan_seg_pkg::SHIFT_IN_OFFSET) begin
                    shift_in_d = pwdata;
                end
                if (wr_access && paddr == scan_seg_pkg::CMD_OFFSET) begin
                    len_d = pwdata[scan_seg_pkg::CMD_LEN_LSB +: LW];
                    if (pwdata[scan_seg_pkg::CMD_CAPTURE_BIT]) begin
                        // Every cell is captured, observe cells included
                        chain_d = {obs_converter, obs_comparator,
                                   latch_q};
                    end
                    if (pwdata[scan_seg_pkg::CMD_SHIFT_BIT]) begin
                        state_d    = scan_seg_pkg::ST_SHIFT;
                        count_d    = pwdata[scan_seg_pkg::CMD_LEN_LSB +: LW];
                        pend_upd_d = pwdata[scan_seg_pkg::CMD_UPDATE_BIT];
                    end else if (pwdata[scan_seg_pkg::CMD_UPDATE_BIT]) begin
                        latch_d = chain_d[CW-1:0];
                    end
                end
            end
            scan_seg_pkg::ST_SHIFT: begin
                // Latches stay put until the last shift, which loads them when an update is pending
                chain_d     = {shift_in_q[0], chain_q[NW-1:1]};
                shift_in_d  = {1'b0, shift_in_q[31:1]};
                shift_out_d = {chain_q[0], shift_out_q[31:1]};
                count_d     = count_q - 5'h01;
                if (count_q == 5'h00) begin
                    state_d    = scan_seg_pkg::ST_IDLE;
                    pend_upd_d = 1'b0;
                    if (pend_upd_q) begin
                        latch_d = chain_d[CW-1:0];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= scan_seg_pkg::ST_IDLE;
            latch_q     <= scan_seg_pkg::CTRL_RESET;
            chain_q     <= {NW{1'b0}};
            shift_in_q  <= 32'h00000000;
            shift_out_q <= 32'h00000000;
            count_q     <= 5'h00;
            len_q       <= 5'h00;
            pend_upd_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            latch_q     <= latch_d;
            chain_q     <= chain_d;
            shift_in_q  <= shift_in_d;
            shift_out_q <= shift_out_d;
            count_q     <= count_d;
            len_q       <= len_d;
            pend_upd_q  <= pend_upd_d;
        end
    end

    // Analog controls driven straight from the update latches
    assign comparator_off =
        latch_q[scan_seg_pkg::CELL_COMPARATOR_OFF];
    assign comparator_mux_select =
        latch_q[scan_seg_pkg::CELL_MUX_SELECT];
    assign comparator_bandgap_enable =
        latch_q[scan_seg_pkg::CELL_BANDGAP_ENABLE];
    assign gain_clock =
        latch_q[scan_seg_pkg::CELL_GAIN_CLOCK];
    assign gain_path_enable =
        latch_q[scan_seg_pkg::CELL_GAIN_PATH_ENABLE];
    assign neg_input_bandgap_select =
        latch_q[scan_seg_pkg::CELL_NEG_BANDGAP];
    assign converter_power_on =
        latch_q[scan_seg_pkg::CELL_CONVERTER_POWER];
    assign gain_stage_power_on =
        latch_q[scan_seg_pkg::CELL_GAIN_POWER];

    // One cell per DAC bit
    genvar gi;
    generate
        for (gi = 0; gi < scan_seg_pkg::DAC_W; gi++) begin : g_dac
            assign dac_code[gi] =
                latch_q[scan_seg_pkg::CELL_DAC_LSB + gi];
        end
    endgenerate

    assign gain_bypass_select =
        latch_q[scan_seg_pkg::CELL_GAIN_BYPASS];
    assign gain_x10_enable =
        latch_q[scan_seg_pkg::CELL_GAIN_X10];
    assign gain_x20_enable =
        latch_q[scan_seg_pkg::CELL_GAIN_X20];
    assign neg_input_ground_select =
        latch_q[scan_seg_pkg::CELL_NEG_GROUND];
    assign sample_hold =
        latch_q[scan_seg_pkg::CELL_SAMPLE_HOLD];

    // Observed results
    assign comparator_result = obs_comparator;
    assign converter_compare = obs_converter;

endmodule

//--- verilog/scan_seg_pkg.sv
// Contract
// - Comparator control and observe signals each own a scan cell.
// - Converter control and observe signals each own a scan cell.
// - Comparator off control powers comparator down; host idles it at 1.
// - Comparator result is observable and reads 0 under idle inputs.
// - Mux select feeds comparator from converter mux; idle 0.
// - Gain stages clocked by a dedicated scan control; idle 0.
// - Gain path to comparator only while its enable is set; idle 0.
// - Reference select puts band-gap on negative input; idle 0.
// - Converter powered only while its power control is set; idle 0.
// - Gain stages powered only while their power control is set; idle 0.
// - Ten-bit DAC code from single cells; idle code bit 9 only. CTRL_RESET loads DAC code 10'h200 accordingly.
// - Bypass control routes channels 0 to 3 around gain; idle 1.
// - Ground select ties negative input to ground; idle 0.
// - Sample while sample/hold low, hold while high; idle 1.
package scan_seg_pkg;

    // Register byte offsets
    localparam logic [11:0] CMD_OFFSET       = 12'h000;
    localparam logic [11:0] SHIFT_IN_OFFSET  = 12'h004;
    localparam logic [11:0] SHIFT_OUT_OFFSET = 12'h008;
    localparam logic [11:0] STATUS_OFFSET    = 12'h00c;
    localparam logic [11:0] LATCH_OFFSET     = 12'h010;

    // Command register fields
    localparam int CMD_CAPTURE_BIT = 0;
    localparam int CMD_SHIFT_BIT   = 1;
    localparam int CMD_UPDATE_BIT  = 2;
    localparam int CMD_LEN_LSB     = 8;
    localparam int CMD_LEN_W       = 5;

    // Status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ACO_BIT  = 1;
    localparam int STAT_COMP_BIT = 2;

    // Chain layout
    localparam int CTRL_W  = 23;
    localparam int CHAIN_W = 25;
    localparam int CELL_COMPARATOR_OFF    = 0;
    localparam int CELL_MUX_SELECT        = 1;
    localparam int CELL_BANDGAP_ENABLE    = 2;
    localparam int CELL_GAIN_CLOCK        = 3;
    localparam int CELL_GAIN_PATH_ENABLE  = 4;
    localparam int CELL_NEG_BANDGAP       = 5;
    localparam int CELL_CONVERTER_POWER   = 6;
    localparam int CELL_GAIN_POWER        = 7;
    localparam int CELL_DAC_LSB           = 8;
    localparam int DAC_W                  = 10;
    localparam int CELL_GAIN_BYPASS       = 18;
    localparam int CELL_GAIN_X10          = 19;
    localparam int CELL_GAIN_X20          = 20;
    localparam int CELL_NEG_GROUND        = 21;
    localparam int CELL_SAMPLE_HOLD       = 22;
    localparam int CELL_OBS_COMPARATOR    = 23;
    localparam int CELL_OBS_CONVERTER     = 24;

    // Idle values of the control cells
    localparam logic [CTRL_W-1:0] CTRL_RESET = 23'h460001;

    typedef enum logic { ST_IDLE, ST_SHIFT } shift_state_t;

endpackage

//--- verif/scan_seg_checker.sv
`timescale 1ns/10ps
module scan_seg_checker (
    // Bus side
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Analog side
    input wire logic        comparator_raw, converter_compare_raw,
    input wire logic        comparator_off, comparator_mux_select,
    input wire logic        comparator_bandgap_enable, comparator_result,
    input wire logic        gain_clock, gain_path_enable,
    input wire logic        neg_input_bandgap_select, converter_power_on,
    input wire logic        gain_stage_power_on,
    input wire logic [9:0]  dac_code,
    input wire logic        gain_bypass_select, gain_x10_enable,
    input wire logic        gain_x20_enable, neg_input_ground_select,
    input wire logic        sample_hold, converter_compare
);
    logic [22:0] ctrl;
    logic        mapped;
    assign ctrl = {sample_hold, neg_input_ground_select, gain_x20_enable,
        gain_x10_enable, gain_bypass_select, dac_code, gain_stage_power_on,
        converter_power_on, neg_input_bandgap_select, gain_path_enable,
        gain_clock, comparator_bandgap_enable, comparator_mux_select,
        comparator_off};
    assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c,
        12'h010};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence rd_setup(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence access;
        psel && penable;
    endsequence
    result_gate_a: assert property (comparator_result ==
        (comparator_raw && !comparator_off)) else $error("result gate");
    off_result_a: assert property (comparator_off |->
        !comparator_result) else $error("result while off");
    conv_gate_a: assert property (converter_compare ==
        (converter_compare_raw && converter_power_on)) else $error("conv");
    idle_vals_a: assert property ($rose(presetn) |->
        ctrl == scan_seg_pkg::CTRL_RESET) else $error("idle values");
    latch_read_a: assert property (rd_setup(12'h010) |=>
        prdata == {9'h0, $past(ctrl)}) else $error("latch read");
    status_read_a: assert property (rd_setup(12'h00c) |=>
        prdata[2:1] == $past({converter_compare, comparator_result}))
        else $error("status read");
    unmapped_a: assert property (access and !mapped |->
        pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped");
    mapped_ok_a: assert property (access and mapped |->
        !pslverr) else $error("mapped error");
endmodule
bind analog_scan_control_segment scan_seg_checker chk_u (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pslverr, .comparator_raw,
    .converter_compare_raw, .comparator_off, .comparator_mux_select,
    .comparator_bandgap_enable, .comparator_result, .gain_clock,
    .gain_path_enable, .neg_input_bandgap_select, .converter_power_on,
    .gain_stage_power_on, .dac_code, .gain_bypass_select, .gain_x10_enable,
    .gain_x20_enable, .neg_input_ground_select, .sample_hold,
    .converter_compare);

//--- verif/analog_front_model.sv
`timescale 1ns/10ps
module analog_front_model #(parameter logic [9:0] LEVEL = 10'h280) (
    // Clock and reset
    input wire logic       pclk, presetn,
    // Controls from the segment
    input wire logic       comparator_off, comparator_mux_select,
    input wire logic       converter_power_on, sample_hold,
    input wire logic [9:0] dac_code,
    // Raw comparator levels
    output logic           comparator_raw, converter_compare_raw
);
    logic [9:0] held_q;
    logic       tog_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_q <= 10'h000;
            tog_q  <= 1'b0;
        end else begin
            tog_q <= !tog_q;
            if (!sample_hold) held_q <= LEVEL;
        end
    end
    // Powered-down stages give no reliable level
    assign comparator_raw = comparator_off ? tog_q :
        comparator_mux_select;
    assign converter_compare_raw = converter_power_on ?
        (held_q > dac_code) : tog_q;
endmodule

//--- verif/tb_analog_scan_control_segment.sv
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_analog_scan_control_segment;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic comparator_raw, converter_compare_raw, comparator_off;
    logic comparator_mux_select, comparator_bandgap_enable, sample_hold;
    logic comparator_result, gain_clock, gain_path_enable, gain_x10_enable;
    logic neg_input_bandgap_select, converter_power_on, gain_stage_power_on;
    logic gain_bypass_select, gain_x20_enable, neg_input_ground_select;
    logic converter_compare;
    logic [9:0] dac_code;
    int errors = 0, check_count = 0, cycles = 0;
    localparam logic [22:0] PAT_A = 23'h020042, PAT_B = 23'h430041;
    analog_scan_control_segment dut_u (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .comparator_raw, .converter_compare_raw, .comparator_off,
        .comparator_mux_select, .comparator_bandgap_enable,
        .comparator_result, .gain_clock, .gain_path_enable,
        .neg_input_bandgap_select, .converter_power_on,
        .gain_stage_power_on, .dac_code, .gain_bypass_select,
        .gain_x10_enable, .gain_x20_enable, .neg_input_ground_select,
        .sample_hold, .converter_compare);
    analog_front_model model_u (.pclk, .presetn, .comparator_off,
        .comparator_mux_select, .converter_power_on, .sample_hold,
        .dac_code, .comparator_raw, .converter_compare_raw);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            close_out();
        end
    end
    task close_out;
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task shift(input logic [24:0] v, input logic [2:0] cmd);
        int n;
        n = 0;
        apb(1'b1, scan_seg_pkg::SHIFT_IN_OFFSET, {7'h0, v});
        apb(1'b1, scan_seg_pkg::CMD_OFFSET, {19'h0, 5'd24, 5'h0, cmd});
        do begin
            apb(1'b0, scan_seg_pkg::STATUS_OFFSET, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 100);
    endtask
    task test_apply(input logic [22:0] p, input logic c, input logic v);
        shift({2'b00, p}, 3'b110);
        apb(1'b0, scan_seg_pkg::LATCH_OFFSET, 32'h0);
        `CHK(rd[22:0], p)
        `CHK(dac_code, p[17:8])
        `CHK(sample_hold, p[22])
        `CHK(comparator_result, c)
        `CHK(converter_compare, v)
        $display("apply %h done", p);
    endtask
    task test_capture;
        shift(25'h0, 3'b011);
        apb(1'b0, scan_seg_pkg::SHIFT_OUT_OFFSET, 32'h0);
        `CHK(rd[31:7], {2'b11, PAT_A})
        apb(1'b0, scan_seg_pkg::LATCH_OFFSET, 32'h0);
        `CHK(rd[22:0], PAT_A)
        $display("capture done");
    endtask
    task test_unmapped;
        apb(1'b0, 12'h020, 32'h0);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h0)
        $display("unmapped done");
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, scan_seg_pkg::LATCH_OFFSET, 32'h0);
        `CHK(rd[22:0], scan_seg_pkg::CTRL_RESET)
        `CHK(comparator_result, 1'b0)
        // Sampling at DAC midpoint, no negative source selected
        test_apply(PAT_A, 1'b1, 1'b1);
        test_capture();
        // Hold raised with gain stages unused
        test_apply(PAT_B, 1'b0, 1'b0);
        test_unmapped();
        test_apply(scan_seg_pkg::CTRL_RESET, 1'b0, 1'b0);
        close_out();
    end
endmodule
